// File: inc/fes_map.svh
`ifndef FES_MAP_SVH
`define FES_MAP_SVH

// timing
`define FES_CLK_MHZ 100
`define FES_T_WIN_US 50
`define FES_T_SUSP_US 15
`define FES_T_ACC_NS 70
`define FES_T_WP_NS 35
`define FES_WIN_CYC (`FES_T_WIN_US * `FES_CLK_MHZ)
`define FES_SUSP_CYC (`FES_T_SUSP_US * `FES_CLK_MHZ)
`define FES_ACC_CYC ((`FES_T_ACC_NS * `FES_CLK_MHZ + 999) / 1000)
`define FES_WP_CYC ((`FES_T_WP_NS * `FES_CLK_MHZ + 999) / 1000)
`define FES_WIN_LAG_CYC 8

// flash command bytes and addresses
`define FES_UNLOCK1_ADDR 21'h005555
`define FES_UNLOCK2_ADDR 21'h002aaa
`define FES_UNLOCK1_DATA 8'haa
`define FES_UNLOCK2_DATA 8'h55
`define FES_SETUP_DATA 8'h80
`define FES_CHIP_DATA 8'h10
`define FES_SECT_DATA 8'h30
`define FES_SUSP_DATA 8'hb0
`define FES_RES_DATA 8'h30
`define FES_PROG_DATA 8'ha0
`define FES_SECT_LSB 16
`define FES_SECT_MSB 20

// flash status bit positions
`define FES_COMPLETION_POLL_BIT 7
`define FES_TOGGLE_STATUS_BIT 6
`define FES_TIME_LIMIT_FAIL_BIT 5
`define FES_ERASE_WINDOW_BIT 3
`define FES_SUSPEND_TOGGLE_BIT 2

// apb register offsets
`define FES_REG_CMD 8'h00
`define FES_REG_ADDR 8'h04
`define FES_REG_WDATA 8'h08
`define FES_REG_STAT 8'h0c

// status register fields
`define FES_STAT_BUSY 0
`define FES_STAT_DONE 1
`define FES_STAT_FAIL 2
`define FES_STAT_REJ 3
`define FES_STAT_SUSP 4
`define FES_STAT_WIN 5
`define FES_STAT_SACT 6
`define FES_STAT_RB 7
`define FES_STAT_RD_LSB 8

`endif

// File: inc/fes_pkg.sv
`default_nettype none
package fes_pkg;
  typedef enum logic [2:0] {
    FES_OP_READ = 3'h0,
    FES_OP_CHIP = 3'h1,
    FES_OP_SECT = 3'h2,
    FES_OP_ADD = 3'h3,
    FES_OP_SUSP = 3'h4,
    FES_OP_RES = 3'h5,
    FES_OP_PROG = 3'h6,
    FES_OP_POLL = 3'h7
  } fes_op_t;

  typedef enum logic [2:0] {
    FES_S_IDLE = 3'h0,
    FES_S_WRITE = 3'h1,
    FES_S_WWAIT = 3'h2,
    FES_S_READ = 3'h3,
    FES_S_RWAIT = 3'h4,
    FES_S_EVAL = 3'h5
  } fes_st_t;

  typedef enum logic [1:0] {
    FES_C_IDLE = 2'h0,
    FES_C_SETUP = 2'h1,
    FES_C_PULSE = 2'h2,
    FES_C_HOLD = 2'h3
  } fes_cst_t;
endpackage : fes_pkg
`default_nettype wire

// File: logic/fes_flash_cycle.sv
`timescale 1ns/1ps
`default_nettype none
`include "fes_map.svh"
module fes_flash_cycle #(
  parameter int WP_CYC = `FES_WP_CYC,
  parameter int ACC_CYC = `FES_ACC_CYC
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic nrst_i,
  // request
  input wire logic go_i,
  input wire logic wr_i,
  input wire logic [20:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic done_o,
  output logic [7:0] rdata_o,
  // flash pins
  output logic ce_n_o,
  output logic oe_n_o,
  output logic we_n_o,
  output logic [20:0] addr_o,
  output logic [7:0] dq_o,
  output logic dq_oe_o,
  input wire logic [7:0] dq_i
);
  typedef struct packed {
    fes_pkg::fes_cst_t st;
    logic [3:0] cnt;
    logic wr;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [20:0] addr;
    logic [7:0] dq;
    logic dq_oe;
    logic [7:0] rdata;
    logic done;
  } fes_cyc_t;

  fes_cyc_t r;
  fes_cyc_t nx;
  logic [3:0] last;

  // last pulse count: write pulse or read access time
  assign last = r.wr ? 4'(WP_CYC - 1) : 4'(ACC_CYC - 1);

  // one flash bus cycle: setup, strobe pulse, hold
  always_comb begin
    nx = r;
    nx.done = 1'b0;
    case (r.st)
      fes_pkg::FES_C_IDLE: begin
        if (go_i) begin
          nx.wr = wr_i;
          nx.addr = addr_i;
          nx.dq = wdata_i;
          nx.dq_oe = wr_i;
          nx.ce_n = 1'b0;
          nx.st = fes_pkg::FES_C_SETUP;
        end
      end
      fes_pkg::FES_C_SETUP: begin
        // address latched by flash on this falling edge
        nx.we_n = ~r.wr;
        nx.oe_n = r.wr;
        nx.cnt = 4'h0;
        nx.st = fes_pkg::FES_C_PULSE;
      end
      fes_pkg::FES_C_PULSE: begin
        nx.cnt = r.cnt + 4'h1;
        if (r.cnt == last) begin
          if (!r.wr) begin
            nx.rdata = dq_i;
          end
          // data byte latched on this rising edge
          nx.we_n = 1'b1;
          nx.oe_n = 1'b1;
          nx.st = fes_pkg::FES_C_HOLD;
        end
      end
      fes_pkg::FES_C_HOLD: begin
        nx.ce_n = 1'b1;
        nx.dq_oe = 1'b0;
        nx.done = 1'b1;
        nx.st = fes_pkg::FES_C_IDLE;
      end
      default: begin
        nx.st = fes_pkg::FES_C_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      r <= '0;
      r.ce_n <= 1'b1;
      r.oe_n <= 1'b1;
      r.we_n <= 1'b1;
      r.st <= fes_pkg::FES_C_IDLE;
    end else begin
      r <= nx;
    end
  end

  // outputs straight from flops
  assign done_o = r.done;
  assign rdata_o = r.rdata;
  assign ce_n_o = r.ce_n;
  assign oe_n_o = r.oe_n;
  assign we_n_o = r.we_n;
  assign addr_o = r.addr;
  assign dq_o = r.dq;
  assign dq_oe_o = r.dq_oe;
endmodule : fes_flash_cycle
`default_nettype wire

// File: logic/fes_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "fes_map.svh"
module fes_ctrl #(
  parameter int WIN_CYC = `FES_WIN_CYC,
  parameter int SUSP_CYC = `FES_SUSP_CYC
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic nrst_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // flash pins
  output logic fl_ce_n_o,
  output logic fl_oe_n_o,
  output logic fl_we_n_o,
  output logic [20:0] fl_addr_o,
  output logic [7:0] fl_dq_o,
  output logic fl_dq_oe_o,
  input wire logic [7:0] fl_dq_i,
  input wire logic ready_busy_output_i
);
  typedef struct packed {
    fes_pkg::fes_st_t st;
    fes_pkg::fes_op_t op;
    logic [2:0] step;
    logic [2:0] last;
    logic [20:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic busy;
    logic done;
    logic fail;
    logic rej;
    logic susp;
    logic inwin;
    logic sact;
    logic retry;
    logic [15:0] wcnt;
    logic [15:0] pcnt;
    logic go;
    logic wr;
    logic [20:0] caddr;
    logic [7:0] cdata;
    logic [31:0] prdata;
  } fes_st_all_t;

  fes_st_all_t r;
  fes_st_all_t nx;
  logic cyc_done;
  logic [7:0] cyc_rdata;
  logic setup;
  logic acc_wr;
  logic mapped;
  logic [31:0] stat;
  logic [20:0] sect_addr;
  logic [28:0] sw;
  logic [2:0] cop;
  logic allowed;
  logic target;
  logic match;

  // one word of a command string: address and data for step s
  function automatic logic [28:0] step_word(
    input fes_pkg::fes_op_t op,
    input logic [2:0] s,
    input logic [20:0] a,
    input logic [7:0] d
  );
    logic [20:0] ua;
    logic [7:0] ud;
    ua = `FES_UNLOCK1_ADDR;
    ud = `FES_UNLOCK1_DATA;
    // unlock pattern shared by the chip, sector and program strings
    if (s == 3'h1 || s == 3'h4) begin
      ua = `FES_UNLOCK2_ADDR;
      ud = `FES_UNLOCK2_DATA;
    end
    case (op)
      fes_pkg::FES_OP_CHIP: begin
        if (s == 3'h2) ud = `FES_SETUP_DATA;
        if (s == 3'h5) ud = `FES_CHIP_DATA;
      end
      fes_pkg::FES_OP_SECT: begin
        if (s == 3'h2) ud = `FES_SETUP_DATA;
        if (s == 3'h5) begin
          ua = a;
          ud = `FES_SECT_DATA;
        end
      end
      fes_pkg::FES_OP_PROG: begin
        if (s == 3'h2) ud = `FES_PROG_DATA;
        if (s == 3'h3) begin
          ua = a;
          ud = d;
        end
      end
      fes_pkg::FES_OP_ADD: begin
        ua = a;
        ud = `FES_SECT_DATA;
      end
      fes_pkg::FES_OP_SUSP: begin
        ua = a; // address is a don't-care
        ud = `FES_SUSP_DATA;
      end
      fes_pkg::FES_OP_RES: begin
        ua = a;
        ud = `FES_RES_DATA;
      end
      default: begin
        ua = a;
      end
    endcase
    return {ua, ud};
  endfunction : step_word

  // sector base: only upper address bits select the sector
  assign sect_addr = {r.addr[`FES_SECT_MSB:`FES_SECT_LSB], 16'h0000};
  assign sw = step_word(r.op, r.step, r.addr, r.wdata);

  // apb decode: always ready, error on unmapped offsets
  assign setup = psel_i & ~penable_i;
  assign acc_wr = psel_i & penable_i & pwrite_i;
  assign mapped = (paddr_i == `FES_REG_CMD) || (paddr_i == `FES_REG_ADDR) ||
                  (paddr_i == `FES_REG_WDATA) || (paddr_i == `FES_REG_STAT);
  assign cop = pwdata_i[2:0];

  // status word seen by software
  always_comb begin
    stat = 32'h0000_0000;
    stat[`FES_STAT_BUSY] = r.busy;
    stat[`FES_STAT_DONE] = r.done;
    stat[`FES_STAT_FAIL] = r.fail;
    stat[`FES_STAT_REJ] = r.rej;
    stat[`FES_STAT_SUSP] = r.susp;
    stat[`FES_STAT_WIN] = r.inwin;
    stat[`FES_STAT_SACT] = r.sact;
    stat[`FES_STAT_RB] = ready_busy_output_i;
    stat[`FES_STAT_RD_LSB +: 8] = r.rdata;
  end

  // which commands may go to the flash in the present phase
  always_comb begin
    allowed = 1'b0;
    if (r.susp) begin
      // while suspended only resume, program and plain reads
      allowed = (cop == 3'(fes_pkg::FES_OP_RES)) ||
                (cop == 3'(fes_pkg::FES_OP_PROG)) ||
                (cop == 3'(fes_pkg::FES_OP_READ));
    end else if (r.sact) begin
      // erase pending: never send a string that would abort it
      allowed = (cop == 3'(fes_pkg::FES_OP_SUSP)) ||
                (cop == 3'(fes_pkg::FES_OP_POLL)) ||
                (cop == 3'(fes_pkg::FES_OP_READ)) ||
                ((cop == 3'(fes_pkg::FES_OP_ADD)) && r.inwin);
    end else begin
      // suspend, resume, add and poll make sense only inside an erase
      allowed = (cop == 3'(fes_pkg::FES_OP_CHIP)) ||
                (cop == 3'(fes_pkg::FES_OP_SECT)) ||
                (cop == 3'(fes_pkg::FES_OP_PROG)) ||
                (cop == 3'(fes_pkg::FES_OP_READ));
    end
  end

  // expected completion poll value: data bit for program, one for erase
  assign target = (r.op == fes_pkg::FES_OP_PROG) ?
                  r.wdata[`FES_COMPLETION_POLL_BIT] : 1'b1;
  assign match = (r.rdata[`FES_COMPLETION_POLL_BIT] == target);

  // registers, window timer and command sequencer
  always_comb begin
    nx = r;
    nx.go = 1'b0;
    // read data prepared in setup, shown in the access phase
    if (setup && !pwrite_i) begin
      case (paddr_i)
        `FES_REG_ADDR: nx.prdata = {11'h000, r.addr};
        `FES_REG_WDATA: nx.prdata = {24'h000000, r.wdata};
        `FES_REG_STAT: nx.prdata = stat;
        default: nx.prdata = 32'h0000_0000;
      endcase
    end
    if (acc_wr && paddr_i == `FES_REG_ADDR) nx.addr = pwdata_i[20:0];
    if (acc_wr && paddr_i == `FES_REG_WDATA) nx.wdata = pwdata_i[7:0];
    // host copy of the window, closed early by the add-to-strobe lag
    if (r.inwin && !r.susp) begin
      if (r.wcnt == 16'(WIN_CYC - 1 - `FES_WIN_LAG_CYC)) begin
        nx.inwin = 1'b0;
      end else begin
        nx.wcnt = r.wcnt + 16'h0001;
      end
    end
    // command accept
    if (acc_wr && paddr_i == `FES_REG_CMD) begin
      nx.done = 1'b0;
      nx.fail = 1'b0;
      nx.rej = 1'b0;
      if (r.busy || !allowed) begin
        nx.rej = 1'b1;
      end else begin
        nx.op = fes_pkg::fes_op_t'(cop);
        nx.busy = 1'b1;
        nx.step = 3'h0;
        nx.retry = 1'b0;
        nx.pcnt = 16'h0000;
        case (fes_pkg::fes_op_t'(cop))
          fes_pkg::FES_OP_CHIP: nx.last = 3'h5;
          fes_pkg::FES_OP_SECT: nx.last = 3'h5;
          fes_pkg::FES_OP_PROG: nx.last = 3'h3;
          default: nx.last = 3'h0;
        endcase
        if (cop == 3'(fes_pkg::FES_OP_READ) ||
            cop == 3'(fes_pkg::FES_OP_POLL)) begin
          nx.st = fes_pkg::FES_S_READ;
        end else begin
          nx.st = fes_pkg::FES_S_WRITE;
        end
      end
    end
    case (r.st)
      fes_pkg::FES_S_IDLE: begin
      end
      fes_pkg::FES_S_WRITE: begin
        nx.go = 1'b1;
        nx.wr = 1'b1;
        if (r.op == fes_pkg::FES_OP_SECT && r.step == r.last) begin
          nx.caddr = sect_addr;
        end else if (r.op == fes_pkg::FES_OP_ADD ||
                     r.op == fes_pkg::FES_OP_RES) begin
          nx.caddr = sect_addr;
        end else begin
          nx.caddr = sw[28:8];
        end
        nx.cdata = sw[7:0];
        nx.st = fes_pkg::FES_S_WWAIT;
      end
      fes_pkg::FES_S_WWAIT: begin
        if (cyc_done) begin
          if (r.step != r.last) begin
            nx.step = r.step + 3'h1;
            nx.st = fes_pkg::FES_S_WRITE;
          end else begin
            case (r.op)
              fes_pkg::FES_OP_SECT, fes_pkg::FES_OP_ADD: begin
                // each accepted sector erase or add 30h reopens the window
                nx.inwin = 1'b1;
                nx.wcnt = 16'h0000;
                nx.sact = 1'b1;
                nx.busy = 1'b0;
                nx.done = 1'b1;
                nx.st = fes_pkg::FES_S_IDLE;
              end
              fes_pkg::FES_OP_RES: begin
                nx.susp = 1'b0; // erase runs again
                nx.busy = 1'b0;
                nx.done = 1'b1;
                nx.st = fes_pkg::FES_S_IDLE;
              end
              fes_pkg::FES_OP_SUSP: begin
                nx.inwin = 1'b0; // window ends at once
                nx.st = fes_pkg::FES_S_READ;
              end
              default: begin
                // chip erase or byte program starts on the last rising strobe
                nx.st = fes_pkg::FES_S_READ;
              end
            endcase
          end
        end
      end
      fes_pkg::FES_S_READ: begin
        nx.go = 1'b1;
        nx.wr = 1'b0;
        // suspend and erase polls go to the erasing sector
        if (r.op == fes_pkg::FES_OP_SUSP || r.op == fes_pkg::FES_OP_POLL) begin
          nx.caddr = sect_addr;
        end else begin
          nx.caddr = r.addr;
        end
        nx.st = fes_pkg::FES_S_RWAIT;
      end
      fes_pkg::FES_S_RWAIT: begin
        nx.pcnt = r.pcnt + 16'h0001;
        if (cyc_done) begin
          nx.rdata = cyc_rdata;
          nx.st = fes_pkg::FES_S_EVAL;
        end
      end
      fes_pkg::FES_S_EVAL: begin
        nx.st = fes_pkg::FES_S_READ;
        nx.pcnt = r.pcnt + 16'h0001;
        if (r.op == fes_pkg::FES_OP_READ) begin
          nx.busy = 1'b0;
          nx.done = 1'b1;
          nx.st = fes_pkg::FES_S_IDLE;
        end else if (match) begin
          // completion poll bit reached its final value
          nx.busy = 1'b0;
          nx.done = 1'b1;
          nx.st = fes_pkg::FES_S_IDLE;
          if (r.op == fes_pkg::FES_OP_SUSP) nx.susp = 1'b1;
          if (r.op == fes_pkg::FES_OP_POLL) nx.sact = 1'b0;
        end else if (r.retry) begin
          // second read after time limit still not complete
          nx.fail = 1'b1;
          nx.busy = 1'b0;
          nx.done = 1'b1;
          nx.st = fes_pkg::FES_S_IDLE;
          if (r.op == fes_pkg::FES_OP_POLL) nx.sact = 1'b0;
        end else if (r.rdata[`FES_TIME_LIMIT_FAIL_BIT]) begin
          nx.retry = 1'b1; // reread: poll bit may flip with the fail bit
        end else if (r.op == fes_pkg::FES_OP_SUSP &&
                     r.pcnt >= 16'(SUSP_CYC)) begin
          // suspend not reached within 15 us
          nx.fail = 1'b1;
          nx.busy = 1'b0;
          nx.done = 1'b1;
          nx.st = fes_pkg::FES_S_IDLE;
        end
      end
      default: begin
        nx.st = fes_pkg::FES_S_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      r <= '0;
      r.st <= fes_pkg::FES_S_IDLE;
      r.op <= fes_pkg::FES_OP_READ;
    end else begin
      r <= nx;
    end
  end

  // one flash bus cycle at a time
  fes_flash_cycle u_cycle (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .go_i(r.go),
    .wr_i(r.wr),
    .addr_i(r.caddr),
    .wdata_i(r.cdata),
    .done_o(cyc_done),
    .rdata_o(cyc_rdata),
    .ce_n_o(fl_ce_n_o),
    .oe_n_o(fl_oe_n_o),
    .we_n_o(fl_we_n_o),
    .addr_o(fl_addr_o),
    .dq_o(fl_dq_o),
    .dq_oe_o(fl_dq_oe_o),
    .dq_i(fl_dq_i)
  );

  // apb answer: zero wait states
  assign prdata_o = r.prdata;
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~mapped;
endmodule : fes_ctrl
`default_nettype wire

// File: verif/fes_ctrl_checker.sv
`timescale 1ns/1ps
`default_nettype none
module fes_ctrl_checker #(
  parameter int WIN_CYC = 5000,
  parameter int SUSP_CYC = 1500
) (
  // clock, reset and apb side
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // flash side
  input wire logic fl_ce_n_o,
  input wire logic fl_oe_n_o,
  input wire logic fl_we_n_o,
  input wire logic [20:0] fl_addr_o,
  input wire logic [7:0] fl_dq_o,
  input wire logic fl_dq_oe_o
);
  logic unmap;
  // offsets outside the four word registers
  assign unmap = paddr_i[1:0] != 2'b00 || paddr_i > 8'h0c;
  logic pgm_data;
  // the write after a0h is program data
  always_ff @(posedge mclk_i)
    if ($fell(fl_we_n_o)) pgm_data <= fl_dq_o == 8'ha0;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  a_ready_always: assert property (pready_o)
    else $error("pready dropped");
  a_err_unmapped: assert property (psel_i && penable_i |-> pslverr_o == unmap)
    else $error("slave error does not match the map");
  a_rd_unmapped: assert property (
    psel_i && penable_i && !pwrite_i && unmap |-> prdata_o == 32'h0)
    else $error("unmapped read returned data");
  a_we_in_cycle: assert property (
    !fl_we_n_o |-> !fl_ce_n_o && fl_oe_n_o && fl_dq_oe_o)
    else $error("write strobe outside a driven cycle");
  a_we_width: assert property (
    $fell(fl_we_n_o) |-> !fl_we_n_o [*4] ##1 fl_we_n_o)
    else $error("write strobe width wrong");
  a_oe_width: assert property (
    $fell(fl_oe_n_o) |-> (!fl_oe_n_o && !fl_dq_oe_o) [*7] ##1 fl_oe_n_o)
    else $error("read strobe width or bus drive wrong");
  a_held_cycle: assert property (
    !fl_ce_n_o && !$past(fl_ce_n_o) |-> $stable(fl_addr_o) && $stable(fl_dq_o))
    else $error("address or data moved inside a cycle");
  a_ce_release: assert property (
    $rose(fl_we_n_o) |=> fl_ce_n_o && !fl_dq_oe_o)
    else $error("select not released after write");
  a_setup_addr: assert property (
    $fell(fl_we_n_o) && !pgm_data && fl_dq_o == 8'h80 |->
    fl_addr_o == 21'h005555)
    else $error("setup byte at wrong address");
  a_unlock_addr: assert property (
    $fell(fl_we_n_o) && !pgm_data && fl_dq_o == 8'h55 |->
    fl_addr_o == 21'h002aaa)
    else $error("second unlock at wrong address");
  a_sector_base: assert property (
    $fell(fl_we_n_o) && !pgm_data && fl_dq_o == 8'h30 |->
    fl_addr_o[15:0] == 16'h0)
    else $error("sector command not at sector base");
  c_chip: cover property ($fell(fl_we_n_o) && fl_dq_o == 8'h10);
  c_susp: cover property ($fell(fl_we_n_o) && fl_dq_o == 8'hb0);
  c_unmap: cover property (psel_i && penable_i && pslverr_o);
endmodule : fes_ctrl_checker
bind fes_ctrl fes_ctrl_checker #(.WIN_CYC(WIN_CYC), .SUSP_CYC(SUSP_CYC))
  i_fes_ctrl_checker (.mclk_i(mclk_i), .nrst_i(nrst_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .fl_ce_n_o(fl_ce_n_o), .fl_oe_n_o(fl_oe_n_o), .fl_we_n_o(fl_we_n_o),
  .fl_addr_o(fl_addr_o), .fl_dq_o(fl_dq_o), .fl_dq_oe_o(fl_dq_oe_o));
`default_nettype wire

// File: verif/fes_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module fes_flash_model #(
  parameter int WIN = 60,
  parameter int BUSY = 200
) (
  // strobes and bus from the controller
  input wire logic mclk_i,
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic [20:0] addr_i,
  input wire logic [7:0] dq_i,
  // fault injection and answers
  input wire logic fail_i,
  output logic [7:0] dq_o,
  output logic rb_o
);
  logic [7:0] mem [int];
  logic [7:0] cur = 8'h00;
  logic [31:0] sel = '0;
  logic [20:0] la = '0;
  logic [20:0] pa = '0;
  logic [7:0] pd = '0;
  logic we_q = 1'b1;
  logic oe_q = 1'b1;
  logic tg = 1'b0;
  logic pb = 1'b0;
  logic pf = 1'b0;
  int st = 0; // 0 read 1 window 2 erase 3 suspended 4 chip 6 suspending
  int seq = 0;
  int tmr = 0;
  int et = 0;
  int pt = 0;
  int q[$];
  initial rb_o = 1'b1;
  // released bus shows the inverse of the last byte, never a stale copy
  assign dq_o = (!ce_n_i && !oe_n_i) ? cur : ~cur;
  // status byte or array data for a read at a
  function automatic logic [7:0] rdv(input logic [20:0] a);
    if (pb && a == pa)
      return {~pd[7], tg, pf, 3'b001, 2'b00};
    if (st == 3 && sel[a[20:16]])
      return {3'b110, 1'b0, 1'b1, tg, 2'b00};
    if (pb || st == 1 || st == 2 || st == 4 || st == 6)
      return {1'b0, tg, 2'b00, st != 1, tg, 2'b00};
    return mem.exists(a) ? mem[a] : 8'hff;
  endfunction : rdv
  // strobe edges, command decode and internal timers
  always @(posedge mclk_i) begin
    if (we_q && !we_n_i && !ce_n_i) begin
      la = addr_i;
      if (st == 1) tmr = WIN;
    end
    if (!we_q && we_n_i) begin
      if (pb || st == 4 || st == 6) seq = 0;
      else if (st != 0 && st != 3 && dq_i == 8'hb0) begin
        st = st == 1 ? 3 : 6;
        tmr = 5;
      end
      else if (st == 1 && dq_i == 8'h30) sel[la[20:16]] = 1'b1;
      else if (st == 1) begin
        st = 0;
        sel = '0;
      end
      else if (st == 3 && seq == 0 && dq_i == 8'h30) st = 2;
      else if (st == 2) seq = 0;
      else if (seq == 0 || seq == 3)
        seq = (dq_i == 8'haa && la == 21'h005555) ? seq + 1 : 0;
      else if (seq == 1 || seq == 4)
        seq = (dq_i == 8'h55 && la == 21'h002aaa) ? seq + 1 : 0;
      else if (seq == 2)
        seq = la != 21'h005555 ? 0 : dq_i == 8'ha0 ? 9 :
          (dq_i == 8'h80 && st == 0) ? 3 : 0;
      else if (seq == 9) begin
        pb = 1'b1;
        pa = la;
        pd = dq_i;
        pt = BUSY;
        seq = 0;
      end
      else begin
        seq = 0;
        et = BUSY;
        if (dq_i == 8'h10 && la == 21'h005555) st = 4;
        else if (dq_i == 8'h30) begin
          st = 1;
          sel = '0;
          sel[la[20:16]] = 1'b1;
          tmr = WIN;
        end
      end
    end
    if (st == 1 || st == 6) tmr = tmr - 1;
    if (st == 1 && tmr == 0) st = 2;
    if (st == 6 && tmr == 0) st = 3;
    if (st == 2 || st == 4) et = et - 1;
    // preprogram and erase shown as the end result
    if ((st == 2 || st == 4) && et == 0) begin
      foreach (mem[k]) if (st == 4 || sel[k[20:16]]) q.push_back(k);
      foreach (q[i]) mem.delete(q[i]);
      q.delete();
      st = 0;
      sel = '0;
    end
    if (pb && pt > 0) pt = pt - 1;
    if (pb && pt == 0 && fail_i) pf = 1'b1;
    else if (pb && pt == 0) begin
      mem[pa] = pd;
      pb = 1'b0;
    end
    if (oe_q && !oe_n_i && !ce_n_i) begin
      cur <= rdv(addr_i);
      tg = ~tg;
    end
    rb_o <= !(pb || st == 1 || st == 2 || st == 4 || st == 6);
    we_q = we_n_i;
    oe_q = oe_n_i;
  end
endmodule : fes_flash_model
`default_nettype wire

// File: verif/fes_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "fes_map.svh"
module fes_ctrl_tb;
  logic mclk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic fail_en = 1'b0;
  logic [31:0] prdata;
  logic [31:0] st;
  logic pready, pslverr, perr, ce_n, oe_n, we_n, dq_oe, rb;
  logic [20:0] fa;
  logic [7:0] dq_h, dq_m, dq_bus;
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;
  always #5 mclk_i = ~mclk_i;
  // shared data wire: controller when enabled, else the flash model
  assign dq_bus = dq_oe ? dq_h : dq_m;
  fes_ctrl #(.WIN_CYC(50), .SUSP_CYC(30)) i_fes_ctrl (.mclk_i(mclk_i),
    .nrst_i(nrst_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .fl_ce_n_o(ce_n), .fl_oe_n_o(oe_n), .fl_we_n_o(we_n),
    .fl_addr_o(fa), .fl_dq_o(dq_h), .fl_dq_oe_o(dq_oe), .fl_dq_i(dq_bus),
    .ready_busy_output_i(rb));
  fes_flash_model #(.WIN(50)) i_fes_flash_model (.mclk_i(mclk_i),
    .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .addr_i(fa), .dq_i(dq_bus),
    .fail_i(fail_en), .dq_o(dq_m), .rb_o(rb));
  // one apb transfer, then an idle cycle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_i);
    penable <= 1'b1;
    do @(posedge mclk_i); while (pready !== 1'b1);
    st = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk_i);
  endtask : apb
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // issue one operation and wait until the controller is idle
  task automatic cmd(input logic [2:0] op, input logic [20:0] a,
                     input logic [7:0] d);
    apb(1'b1, `FES_REG_ADDR, {11'h0, a});
    apb(1'b1, `FES_REG_WDATA, {24'h0, d});
    apb(1'b1, `FES_REG_CMD, {29'h0, op});
    do apb(1'b0, `FES_REG_STAT, 32'h0); while (st[0] !== 1'b0);
  endtask : cmd
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  // watchdog, several times the expected run length
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      summarize();
    end
  end
  initial begin
    repeat (2) @(posedge mclk_i);
    nrst_i <= 1'b1;
    // reset values, field widths and an unmapped offset
    apb(1'b0, `FES_REG_STAT, 32'h0);
    check("stat reset", st, 32'h80);
    apb(1'b1, `FES_REG_ADDR, 32'hffffffff);
    apb(1'b0, `FES_REG_ADDR, 32'h0);
    check("addr mask", st, 32'h001fffff);
    apb(1'b1, `FES_REG_WDATA, 32'hffffffff);
    apb(1'b0, `FES_REG_WDATA, 32'h0);
    check("wdata mask", st, 32'hff);
    apb(1'b0, `FES_REG_CMD, 32'h0);
    check("cmd read", st, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    check("unmapped err", perr, 1'b1);
    check("unmapped data", st, 32'h0);
    $display("test registers done");
    // whole array erase, then programs in three sectors
    cmd(3'h1, 21'h0, 8'h0);
    check("chip erase", st[3:0], 4'h2);
    cmd(3'h0, 21'h040010, 8'h0);
    check("erased byte", st[15:8], 8'hff);
    cmd(3'h6, 21'h040010, 8'h5a);
    check("program", st[3:0], 4'h2);
    cmd(3'h6, 21'h030020, 8'ha5);
    cmd(3'h6, 21'h050004, 8'h11);
    $display("test chip erase and program done");
    // two sectors loaded in one window, neighbour kept
    cmd(3'h2, 21'h031234, 8'h0);
    check("window open", st[7:5], 3'h3);
    cmd(3'h3, 21'h050000, 8'h0);
    check("add sector", st[3], 1'b0);
    cmd(3'h7, 21'h030000, 8'h0);
    check("erase done", st[6:0], 7'h02);
    cmd(3'h0, 21'h030020, 8'h0);
    check("first sector", st[15:8], 8'hff);
    cmd(3'h0, 21'h050004, 8'h0);
    check("added sector", st[15:8], 8'hff);
    cmd(3'h0, 21'h040010, 8'h0);
    check("kept sector", st[15:8], 8'h5a);
    // a late add is refused once the window has run out
    cmd(3'h2, 21'h060000, 8'h0);
    do apb(1'b0, `FES_REG_STAT, 32'h0); while (st[5] === 1'b1);
    cmd(3'h3, 21'h070000, 8'h0);
    check("late add", st[3], 1'b1);
    cmd(3'h7, 21'h060000, 8'h0);
    check("late erase done", st[3:0], 4'h2);
    $display("test sector erase done");
    // suspend, program elsewhere, resume, suspend again
    cmd(3'h4, 21'h0, 8'h0);
    check("idle suspend", st[3], 1'b1);
    cmd(3'h2, 21'h080000, 8'h0);
    cmd(3'h4, 21'h080000, 8'h0);
    check("suspended", {st[7], st[4:0]}, 6'h32);
    cmd(3'h1, 21'h0, 8'h0);
    check("no chip erase", st[4:3], 2'h3);
    cmd(3'h4, 21'h080000, 8'h0);
    check("second suspend", st[4:3], 2'h3);
    cmd(3'h6, 21'h090000, 8'h3c);
    check("suspend program", st[4:0], 5'h12);
    cmd(3'h0, 21'h090000, 8'h0);
    check("suspend read", st[15:8], 8'h3c);
    cmd(3'h5, 21'h080000, 8'h0);
    check("resumed", st[4:3], 2'h0);
    cmd(3'h4, 21'h080000, 8'h0);
    check("suspend again", st[4:0], 5'h12);
    cmd(3'h5, 21'h080000, 8'h0);
    cmd(3'h7, 21'h080000, 8'h0);
    check("resumed erase done", st[4:0], 5'h02);
    $display("test suspend done");
    // program that never completes reports a failure
    fail_en <= 1'b1;
    cmd(3'h6, 21'h0a0000, 8'h00);
    check("time limit", st[2], 1'b1);
    $display("test time limit done");
    summarize();
  end
endmodule : fes_ctrl_tb
`default_nettype wire
